// ==== rtl/dma_channel_control.sv ====
// DMA module and per-channel control, arbiter and AXI4-Lite register slave.
//
// Behaviour
// RULE1 - Module control bit 15 turns the whole engine on when set and off when clear.
// RULE2 - Module suspend bit 12 stops new transfers so the CPU keeps the data bus.
// RULE3 - Module active bit 11 reads 1 while active, 0 only when disabled and idle.
// RULE4 - Channel active bit 15 reads 1 while the channel is enabled or still moving data.
// RULE5 - Chain direction bit 8 picks the lower (set) or higher (clear) neighbour as trigger; the code takes channel+1 when set, channel-1 when clear.
// RULE6 - The chain direction has no effect unless chain allow is set.
// RULE7 - Channel enable bit 7 enables transfers when set and disables them when clear.
// RULE8 - Events-when-disabled bit 6 lets start and abort events register on a disabled channel.
// RULE9 - Only a channel with chain allow set is enabled by its neighbour's completion.
// RULE10 - With auto enable bit 4 clear, block completion clears the enable; set keeps it.
// RULE11 - Read-only event detected bit 2 is set by hardware when a channel event is seen.
// RULE12 - Priority bits 1-0 arbitrate from 0 (lowest) to 3 (highest).
// RULE13 - Clearing enable suspends only after the current transaction ends; poll active.
// RULE14 - Bits 31-16 and other unassigned bits read zero and ignore writes.
// RULE15 - Software avoids register access right after clearing the module enable.
// RULE16 - Among equal priorities the lowest channel number wins.
module dma_channel_control
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [dma_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dma_ctl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [dma_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dma_ctl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel events
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] start_event,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] abort_event,
  // Transfer word source
  input wire logic [dma_ctl_pkg::DATA_W-1:0] src_data,
  // Transfer word stream towards the data bus
  output logic xfer_valid,
  input wire logic xfer_ready,
  output logic [dma_ctl_pkg::DATA_W-1:0] xfer_data,
  output logic [dma_ctl_pkg::CH_W-1:0] xfer_channel,
  // Channel completion pulses
  output logic [dma_ctl_pkg::NUM_CH-1:0] block_done
);
  import dma_ctl_pkg::*;
  typedef enum logic [1:0] {IDLE, MOVE, DRAIN} eng_e;
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic mod_enable_ff, mod_suspend_ff, xfer_valid_ff, aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0] block_length_ff, word_cnt_ff;
  logic [NUM_CH-1:0] ch_enable_ff, ch_chain_dir_ff, ch_evt_dis_ff, ch_chain_allow_ff, ch_auto_ff;
  logic [NUM_CH-1:0] ch_evt_det_ff, ch_pending_ff, block_done_ff;
  logic [1:0] ch_pri_ff [NUM_CH];
  eng_e state_ff;
  logic [CH_W-1:0] cur_ch_ff, xfer_channel_ff;
  logic [1:0] beat_cnt_ff, bresp_ff, rresp_ff;
  logic [DATA_W-1:0] xfer_data_ff, wdata_ff, rdata_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [3:0] wstrb_ff;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Returns channel index + 1 for a channel register, 0 otherwise.
  function automatic logic [2:0] ch_hit(input logic [ADDR_W-1:0] addr);
    logic [2:0] hit;
    hit = 3'd0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (addr == CHANNEL_CONTROL_BASE + CHANNEL_STRIDE * 8'(i)) begin
        hit = 3'(i + 1);
      end
    end
    return hit;
  endfunction : ch_hit

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == MODULE_CONTROL_OFFSET) || (addr == BLOCK_LENGTH_OFFSET)
        || (ch_hit(addr) != 3'd0);
  endfunction : addr_mapped

  logic wr_go;
  logic [2:0] wr_ch;
  logic [DATA_W-1:0] wmask, wval;
  assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ch = ch_hit(awaddr_ff);
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wval = wdata_ff & wmask;

  // ---------------------------------------------------------------------------
  // Channel activity and arbitration
  // ---------------------------------------------------------------------------
  logic busy, grant_ok, last_word, buf_in_ready, buf_out_valid, buf_push;
  logic [NUM_CH-1:0] ch_active, chain_trig;
  logic [CH_W-1:0] grant_ch;
  logic [DATA_W-1:0] buf_out_data;
  assign busy = (state_ff != IDLE);
  assign buf_push = (state_ff == MOVE) && (beat_cnt_ff == 2'd0);
  assign last_word = (word_cnt_ff == block_length_ff - 8'd1);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      localparam int LO = (g + 1) % NUM_CH;
      localparam int HI = (g + NUM_CH - 1) % NUM_CH;
      // RULE4 active includes draining
      assign ch_active[g] = ch_enable_ff[g] || (busy && cur_ch_ff == CH_W'(g));
      // RULE5 RULE6 RULE9 chain trigger pick
      assign chain_trig[g] = ch_chain_allow_ff[g] &&
          (ch_chain_dir_ff[g] ? block_done_ff[LO] : block_done_ff[HI]);
  end

  // RULE12 RULE16 priority arbiter
  always_comb begin
    logic [1:0] best;
    best = 2'd0;
    grant_ok = 1'b0;
    grant_ch = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_enable_ff[i] && ch_pending_ff[i] && (!grant_ok || ch_pri_ff[i] > best)) begin
        grant_ok = 1'b1;
        best = ch_pri_ff[i];
        grant_ch = CH_W'(i);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= IDLE;
      cur_ch_ff <= '0;
      word_cnt_ff <= 8'd0;
      beat_cnt_ff <= 2'd0;
      block_done_ff <= '0;
    end else begin
      block_done_ff <= '0;
      case (state_ff)
        IDLE: begin
          // RULE1 RULE2 no start when off or suspended
          if (mod_enable_ff && !mod_suspend_ff && grant_ok) begin
            state_ff <= MOVE;
            cur_ch_ff <= grant_ch;
            word_cnt_ff <= 8'd0;
            beat_cnt_ff <= 2'd0;
          end
        end
        MOVE: begin
          // A stalled buffer holds the beat, so no word is dropped.
          if (beat_cnt_ff != 2'd0) begin
            beat_cnt_ff <= beat_cnt_ff - 2'd1;
          end else if (buf_in_ready) begin
            beat_cnt_ff <= 2'(TRANSACTION_CYCLES - 1);
            word_cnt_ff <= word_cnt_ff + 8'd1;
            // RULE13 stop only between transactions
            if (last_word) begin
              state_ff <= DRAIN;
              block_done_ff[cur_ch_ff] <= 1'b1;
            end else if (!ch_enable_ff[cur_ch_ff] || !mod_enable_ff || mod_suspend_ff) begin
              state_ff <= DRAIN;
            end
          end
        end
        DRAIN: begin
          if (!buf_out_valid && !xfer_valid_ff) begin
            state_ff <= IDLE;
          end
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  dma_word_buffer u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(src_data),
    .out_valid(buf_out_valid),
    .out_ready(!xfer_valid_ff || xfer_ready),
    .out_data(buf_out_data)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_valid_ff <= 1'b0;
      xfer_data_ff <= REG_RESET;
      xfer_channel_ff <= '0;
    end else if (!xfer_valid_ff || xfer_ready) begin
      xfer_valid_ff <= buf_out_valid;
      xfer_data_ff <= buf_out_data;
      xfer_channel_ff <= cur_ch_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Channel control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_enable_ff <= '0;
      ch_chain_dir_ff <= '0;
      ch_evt_dis_ff <= '0;
      ch_chain_allow_ff <= '0;
      ch_auto_ff <= '0;
      ch_evt_det_ff <= '0;
      ch_pending_ff <= '0;
      ch_pri_ff <= '{default: 2'd0};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // RULE7 RULE14 software writes, unassigned bits dropped
        if (wr_go && wr_ch == 3'(i + 1)) begin
          if (wstrb_ff[1]) begin
            ch_chain_dir_ff[i] <= wval[CH_CHAIN_DIR_BIT];
          end
          if (wstrb_ff[0]) begin
            ch_enable_ff[i] <= wval[CH_ENABLE_BIT];
            ch_evt_dis_ff[i] <= wval[CH_EVT_DIS_BIT];
            ch_chain_allow_ff[i] <= wval[CH_CHAIN_ALLOW_BIT];
            ch_auto_ff[i] <= wval[CH_AUTO_BIT];
            ch_pri_ff[i] <= wval[CH_PRI_LSB+1:CH_PRI_LSB];
          end
        end
        // RULE10 auto clear on completion
        if (block_done_ff[i]) begin
          ch_pending_ff[i] <= 1'b0;
          if (!ch_auto_ff[i]) begin
            ch_enable_ff[i] <= 1'b0;
          end
        end
        // RULE9 chained enable
        if (chain_trig[i]) begin
          ch_enable_ff[i] <= 1'b1;
          ch_pending_ff[i] <= 1'b1;
        end
        // RULE8 RULE11 events gated by enable
        if ((ch_enable_ff[i] || ch_evt_dis_ff[i]) && (start_event[i] || abort_event[i])) begin
          ch_evt_det_ff[i] <= 1'b1;
          ch_pending_ff[i] <= start_event[i] && !abort_event[i];
        end else if (grant_ok && state_ff == IDLE && grant_ch == CH_W'(i) && mod_enable_ff
            && !mod_suspend_ff) begin
          ch_evt_det_ff[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Module control and block length
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_enable_ff <= 1'b0;
      mod_suspend_ff <= 1'b0;
      block_length_ff <= BLOCK_LENGTH_RESET;
    end else if (wr_go && wstrb_ff[1] && awaddr_ff == MODULE_CONTROL_OFFSET) begin
      // RULE1 RULE2 RULE15 enable and suspend
      mod_enable_ff <= wval[MOD_ENABLE_BIT];
      mod_suspend_ff <= wval[MOD_SUSPEND_BIT];
    end else if (wr_go && wstrb_ff[0] && awaddr_ff == BLOCK_LENGTH_OFFSET) begin
      // A zero length would run 256 words before completing, so it is held at one.
      block_length_ff <= (wval[7:0] == 8'd0) ? 8'd1 : wval[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;
  logic [2:0] rd_ch;
  assign rd_ch = ch_hit({s_axi_araddr[ADDR_W-1:2], 2'b00});

  always_comb begin
    // RULE14 unassigned bits read zero
    rd_word = REG_RESET;
    if ({s_axi_araddr[ADDR_W-1:2], 2'b00} == MODULE_CONTROL_OFFSET) begin
      rd_word[MOD_ENABLE_BIT] = mod_enable_ff;
      rd_word[MOD_SUSPEND_BIT] = mod_suspend_ff;
      // RULE3 active unless off and idle
      rd_word[MOD_ACTIVE_BIT] = mod_enable_ff || busy;
    end else if ({s_axi_araddr[ADDR_W-1:2], 2'b00} == BLOCK_LENGTH_OFFSET) begin
      rd_word[7:0] = block_length_ff;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (rd_ch == 3'(i + 1)) begin
          rd_word[CH_ACTIVE_BIT] = ch_active[i];
          rd_word[CH_CHAIN_DIR_BIT] = ch_chain_dir_ff[i];
          rd_word[CH_ENABLE_BIT] = ch_enable_ff[i];
          rd_word[CH_EVT_DIS_BIT] = ch_evt_dis_ff[i];
          rd_word[CH_CHAIN_ALLOW_BIT] = ch_chain_allow_ff[i];
          rd_word[CH_AUTO_BIT] = ch_auto_ff[i];
          rd_word[CH_EVT_DET_BIT] = ch_evt_det_ff[i];
          rd_word[CH_PRI_LSB+1:CH_PRI_LSB] = ch_pri_ff[i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= REG_RESET;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= addr_mapped({s_axi_araddr[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign xfer_valid = xfer_valid_ff;
  assign xfer_data = xfer_data_ff;
  assign xfer_channel = xfer_channel_ff;
  assign block_done = block_done_ff;
endmodule : dma_channel_control

// ==== rtl/dma_ctl_pkg.sv ====
// Package: register map, field positions, reset values and timing of the DMA control block.
package dma_ctl_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CH_W = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MODULE_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] CHANNEL_CONTROL_BASE = 8'h10;
  localparam logic [7:0] CHANNEL_STRIDE = 8'h04;
  localparam logic [7:0] BLOCK_LENGTH_OFFSET = 8'h08;

  // ---------------------------------------------------------------------------
  // Module control fields
  // ---------------------------------------------------------------------------
  localparam int unsigned MOD_ENABLE_BIT = 15;
  localparam int unsigned MOD_SUSPEND_BIT = 12;
  localparam int unsigned MOD_ACTIVE_BIT = 11;

  // ---------------------------------------------------------------------------
  // Channel control fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CH_ACTIVE_BIT = 15;
  localparam int unsigned CH_CHAIN_DIR_BIT = 8;
  localparam int unsigned CH_ENABLE_BIT = 7;
  localparam int unsigned CH_EVT_DIS_BIT = 6;
  localparam int unsigned CH_CHAIN_ALLOW_BIT = 5;
  localparam int unsigned CH_AUTO_BIT = 4;
  localparam int unsigned CH_EVT_DET_BIT = 2;
  localparam int unsigned CH_PRI_LSB = 0;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [7:0] BLOCK_LENGTH_RESET = 8'h04;
  localparam int unsigned TRANSACTION_CYCLES = 3;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : dma_ctl_pkg

// ==== rtl/dma_word_buffer.sv ====
// Two-entry valid/ready buffer carrying transfer words.
module dma_word_buffer
  import dma_ctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data
);

  logic [DATA_W-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != 2'd2);
  assign out_valid = (count_ff != 2'd0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 2'd1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 2'd1;
      end
    end
  end

endmodule : dma_word_buffer

// ==== verification/dma_bus_sink.sv ====
// Model of the data bus that takes transfer words, with stall and slow modes.
module dma_bus_sink
  import dma_ctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Behaviour controls
  input wire logic stall,
  input wire logic slow,
  // Word stream
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [dma_ctl_pkg::DATA_W-1:0] xfer_data,
  input wire logic [dma_ctl_pkg::CH_W-1:0] xfer_channel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [33:0] got_q[$];
  initial xfer_ready = 1'b0;
  // Slow mode accepts every other cycle, so the engine must hold its word.
  always @(posedge aclk) begin
    if (aresetn && xfer_valid && xfer_ready) begin
      got_q.push_back({xfer_channel, xfer_data});
    end
    xfer_ready <= aresetn && !stall && (!slow || !xfer_ready);
  end
endmodule : dma_bus_sink

// ==== verification/dma_channel_control_test.sv ====
// Self-checking bench for the DMA control block.
module dma_channel_control_test;
  import dma_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [31:0] src_data = '0;
  logic [31:0] xfer_data;
  logic [3:0] start_event = '0;
  logic [3:0] abort_event = '0;
  logic [3:0] block_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, xfer_channel;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, stall = 0, slow = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic xfer_valid, xfer_ready;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rv;

  dma_channel_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .start_event, .abort_event, .src_data, .xfer_valid,
    .xfer_ready, .xfer_data, .xfer_channel, .block_done);
  dma_bus_sink sink (.aclk, .aresetn, .stall, .slow, .xfer_valid, .xfer_ready, .xfer_data,
    .xfer_channel);

  initial forever #2 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Write one word and check its answer code.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'd0, s_axi_bresp}, {30'd0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'd0, s_axi_rresp}, {30'd0, er});
  endtask : rd

  // Polls until the active bit drops, since a stop waits for the current transaction.
  task automatic idle_wait(input logic [7:0] a, input int bit_no);
    int n;
    n = 0;
    rd(a, rv);
    while (rv[bit_no] !== 1'b0 && n < 50) begin
      rd(a, rv);
      n++;
    end
  endtask : idle_wait

  task automatic fire(input logic [3:0] m);
    @(posedge aclk);
    start_event <= m;
    @(posedge aclk);
    start_event <= 4'h0;
  endtask : fire

  // Waits for n words, then compares each channel number in order.
  task automatic take(input int n, input logic [7:0] chans);
    logic [33:0] w;
    int k;
    k = 0;
    while (sink.got_q.size() < n && k < 400) begin
      @(posedge aclk);
      k++;
    end
    chk("word count", sink.got_q.size(), n);
    for (int i = 0; i < n && sink.got_q.size() > 0; i++) begin
      w = sink.got_q.pop_front();
      chk("word data", w[31:0], src_data);
      chk("word channel", {30'd0, w[33:32]}, {30'd0, chans[2*i +: 2]});
    end
  endtask : take

  task automatic regs_test();
    rd(8'h00, rv);
    chk("module reset", rv, REG_RESET);
    rd(8'h08, rv);
    chk("length reset", rv, 32'h0000_0004);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, rv);
    chk("module all ones", rv, 32'h0000_9800);
    wr(8'h00, 32'h0000_0000);
    idle_wait(8'h00, MOD_ACTIVE_BIT);
    chk("module off", rv, 32'h0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, rv);
    chk("channel all ones", rv, 32'h0000_81F3);
    wr(8'h14, 32'h0000_0000);
    rd(8'h14, rv);
    chk("channel off", rv, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001, RESP_SLVERR);
    rd(8'h24, rv, RESP_SLVERR);
  endtask : regs_test

  task automatic stream_test();
    src_data <= 32'h1234_5678;
    wr(8'h00, 32'h0000_8000);
    wr(8'h08, 32'h0000_0002);
    wr(8'h10, 32'h0000_0080);
    fire(4'b0001);
    take(2, 8'h00);
    idle_wait(8'h10, CH_ACTIVE_BIT);
    chk("auto clear", rv, 32'h0000_0000);
    stall <= 1'b1;
    wr(8'h08, 32'h0000_0004);
    wr(8'h10, 32'h0000_0090);
    fire(4'b0001);
    repeat (40) @(posedge aclk);
    chk("held word", {31'd0, xfer_valid}, 32'h0000_0001);
    stall <= 1'b0;
    slow <= 1'b1;
    take(4, 8'h00);
    slow <= 1'b0;
    rd(8'h10, rv);
    chk("auto keep", rv, 32'h0000_8090);
    wr(8'h10, 32'h0000_0000);
  endtask : stream_test

  task automatic order_test();
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_9000);
    wr(8'h10, 32'h0000_0080);
    wr(8'h14, 32'h0000_0081);
    wr(8'h18, 32'h0000_0083);
    wr(8'h1C, 32'h0000_0081);
    fire(4'b1111);
    repeat (20) @(posedge aclk);
    chk("suspended", sink.got_q.size(), 0);
    wr(8'h00, 32'h0000_8000);
    take(4, 8'b00_11_01_10);
  endtask : order_test

  task automatic chain_test();
    wr(8'h10, 32'h0000_0080);
    wr(8'h14, 32'h0000_0020);
    wr(8'h18, 32'h0000_0120);
    wr(8'h1C, 32'h0000_0100);
    fire(4'b0001);
    take(2, 8'b00_00_01_00);
    repeat (30) @(posedge aclk);
    chk("chain limit", sink.got_q.size(), 0);
  endtask : chain_test

  task automatic event_test();
    wr(8'h18, 32'h0000_0000);
    wr(8'h1C, 32'h0000_0040);
    fire(4'b1100);
    rd(8'h18, rv);
    chk("ignored event", rv, 32'h0000_0000);
    rd(8'h1C, rv);
    chk("kept event", rv, 32'h0000_0044);
    @(posedge aclk);
    abort_event <= 4'b1000;
    @(posedge aclk);
    abort_event <= 4'b0000;
  endtask : event_test

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    regs_test();
    stream_test();
    order_test();
    chain_test();
    event_test();
    tally_and_finish();
  end

  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule : dma_channel_control_test

// ==== verification/dma_ctl_checker.sv ====
// Concurrent port checks for the DMA control block.
module dma_ctl_checker
  import dma_ctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [dma_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [dma_ctl_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Word stream
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic [dma_ctl_pkg::DATA_W-1:0] xfer_data,
  input wire logic [dma_ctl_pkg::CH_W-1:0] xfer_channel,
  input wire logic [dma_ctl_pkg::NUM_CH-1:0] block_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic unmapped;
  assign unmapped = !(s_axi_awaddr inside {8'h00, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C});
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    ##[1:3] s_axi_bvalid;
  endsequence
  write_answer_a: assert property (wr_taken |-> wr_answer) else $error("no write answer");
  write_hole_a: assert property (wr_taken ##0 unmapped |-> wr_answer ##0 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  bus_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  word_hold_a: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable({xfer_data, xfer_channel}))
    else $error("word lost under stall");
  done_pulse_a: assert property (block_done != 0 |=> (block_done & $past(block_done)) == 0)
    else $error("completion pulse too long");
endmodule : dma_ctl_checker

bind dma_channel_control dma_ctl_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_data(xfer_data),
  .xfer_channel(xfer_channel), .block_done(block_done));
